// *** shared/hbd_params.svh ***
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH
// ----------------------------------------
// register window and vectors
// ----------------------------------------
`define HBD_CSR_BASE    16'hff20
`define HBD_VEC_DEF     16'h0088
`define HBD_VEC_ALT     16'h00ac
// ----------------------------------------
// dma burst and buffer sizing
// ----------------------------------------
`define HBD_BURST_SHORT 3'h2
`define HBD_BURST_LONG  3'h4
`define HBD_FIFO_DEPTH  8
`define HBD_ADDR_STEP   22'h000002
`endif

// *** shared/hbd_pkg.sv ***
package hbd_pkg;
    // bus control lines, one bit per line, 1 = asserted
    typedef struct packed {
        logic sync;
        logic din;
        logic dout;
        logic rply;
        logic wtbt;
        logic bs7;
    } hbd_ctl_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  idx;
        logic [15:0] data;
    } hbd_pio_t;

    typedef struct packed {
        logic [21:0] addr;
        logic        to_mem;
        logic        burst4;
        logic        block;
    } hbd_dma_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ  = 3'h1,
        ST_ADDR = 3'h3,
        ST_SYNC = 3'h2,
        ST_DATA = 3'h6,
        ST_DONE = 3'h7
    } hbd_state_t;
endpackage

// *** hdl/hbd_port.sv ***
`timescale 1ns/1ps
`include "hbd_params.svh"

// ----------------------------------------
// data buffer
// ----------------------------------------
module hbd_fifo #(
    parameter int W = 16,
    parameter int D = `HBD_FIFO_DEPTH
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_clr,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = D[AW:0];
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          rdy_q, rdy_d, vld_q, vld_d, push, pop;

    always_comb begin
        push  = i_valid && rdy_q;
        pop   = vld_q && i_ready;
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (i_clr) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
        rdy_d = (cnt_d != FULL);
        vld_d = (cnt_d != '0);
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    // storage carries no reset; only the pointers, count and ready/valid flags need a defined value
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wp_q] <= i_data;
        end
    end

    assign o_ready = rdy_q;
    assign o_valid = vld_q;
    assign o_data  = mem_q[rp_q];
endmodule // hbd_fifo

// ----------------------------------------
// host bus port
// ----------------------------------------
module hbd_port #(
    parameter logic [15:0] P_CSR_BASE = `HBD_CSR_BASE,
    parameter logic [15:0] P_VEC_DEF  = `HBD_VEC_DEF,
    parameter logic [15:0] P_VEC_ALT  = `HBD_VEC_ALT,
    parameter int          P_DEPTH    = `HBD_FIFO_DEPTH
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_init_l,
    input  wire hbd_pkg::hbd_ctl_t     i_ctl_l,
    output hbd_pkg::hbd_ctl_t          o_ctl_l,
    output hbd_pkg::hbd_ctl_t          o_ctl_oe,
    input  wire logic [15:0]           i_dal_l,
    output logic [15:0]                o_dal_l,
    output logic                       o_dal_oe,
    output logic [5:0]                 o_xdal_l,
    output logic                       o_xdal_oe,
    input  wire logic                  i_ref_l,
    output logic                       o_dmr_l,
    output logic                       o_sack_l,
    input  wire logic                  i_dmgi_l,
    output logic                       o_dmgo_l,
    output logic                       o_irq5_l,
    input  wire logic                  i_iaki_l,
    output logic                       o_iako_l,
    output logic                       o_evnt_l,
    output hbd_pkg::hbd_pio_t          o_pio,
    input  wire logic [15:0]           i_pio_rdata,
    input  wire logic                  i_dma_go,
    input  wire hbd_pkg::hbd_dma_cmd_t i_dma_cmd,
    output logic                       o_dma_busy,
    input  wire logic                  i_wr_valid,
    output logic                       o_wr_ready,
    input  wire logic [15:0]           i_wr_data,
    output logic                       o_rd_valid,
    output logic [15:0]                o_rd_data,
    input  wire logic                  i_ready_flag,
    input  wire logic                  i_attn,
    input  wire logic                  i_err,
    input  wire logic                  i_int_en,
    input  wire logic                  i_vec_sel,
    input  wire logic                  i_rtc_en,
    input  wire logic                  i_rtc_evt
);
    import hbd_pkg::*;

    // vector table, loaded from parameters like a small prom
    localparam logic [15:0] VEC_LUT [2] = '{P_VEC_DEF, P_VEC_ALT};

    hbd_ctl_t    bin, ctl_q, ctl_d, ctl_n_q;
    hbd_state_t  st_q, st_d;
    hbd_pio_t    pio_q, pio_d;
    logic [21:0] addr_q, addr_d;
    logic [15:0] dal_in, dal_d, dal_n_q, rdd_q, rdd_d, fifo_data;
    logic [5:0]  xdal_n_q, xdal_d;
    logic [3:0]  idx_q, idx_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        to_mem_q, to_mem_d, blk_q, blk_d, dmr_q, dmr_d, sack_q, sack_d;
    logic        dmgo_q, dmgo_d, iako_q, iako_d, dal_oe_q, dal_oe_d, xdal_oe_q, xdal_oe_d;
    logic        sel_q, sel_d, sync_in_q, rdv_q, rdv_d, busy_q, busy_d;
    logic        pend_q, pend_d, irq_n_q, irq_d, hold_q, hold_d, evnt_n_q, evnt_d;
    logic        rdy_q, attn_q, err_q, ie_q;
    logic        init, dmg_in, iak_in, ref_in, fifo_valid, fifo_pop, slave_ok, req, evt;

    assign bin    = ~i_ctl_l;
    assign dal_in = ~i_dal_l;
    assign init   = ~i_init_l;
    assign dmg_in = ~i_dmgi_l;
    assign iak_in = ~i_iaki_l;
    assign ref_in = ~i_ref_l;

    hbd_fifo #(.W(16), .D(P_DEPTH)) u_wr_fifo (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clr     (init),
        .i_valid   (i_wr_valid),
        .o_ready   (o_wr_ready),
        .i_data    (i_wr_data),
        .o_valid   (fifo_valid),
        .i_ready   (fifo_pop),
        .o_data    (fifo_data)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        st_d = st_q; addr_d = addr_q; to_mem_d = to_mem_q; blk_d = blk_q; cnt_d = cnt_q;
        dmr_d = dmr_q; sack_d = sack_q; busy_d = busy_q; ctl_d = '0; dal_d = '0;
        dal_oe_d = 1'b0; xdal_d = '0; xdal_oe_d = 1'b0; sel_d = sel_q; idx_d = idx_q;
        pio_d = '0; rdv_d = 1'b0; rdd_d = rdd_q; pend_d = pend_q; fifo_pop = 1'b0;
        hold_d = hold_q && iak_in;
        case (st_q)
            ST_IDLE: if (i_dma_go) begin
                addr_d   = i_dma_cmd.addr;
                to_mem_d = i_dma_cmd.to_mem;
                blk_d    = i_dma_cmd.block;
                cnt_d    = i_dma_cmd.burst4 ? `HBD_BURST_LONG : `HBD_BURST_SHORT;
                dmr_d    = 1'b1;
                busy_d   = 1'b1;
                st_d     = ST_REQ;
            end
            // wait for the previous master to let go of sync and reply
            ST_REQ: if (dmg_in && !bin.sync && !bin.rply) begin
                sack_d = 1'b1;
                dmr_d  = 1'b0;
                st_d   = ST_ADDR;
            end
            ST_ADDR: st_d = ST_SYNC;
            ST_SYNC: st_d = ST_DATA;
            ST_DATA: if (bin.rply && (ctl_q.din || ctl_q.dout)) begin
                rdv_d    = !to_mem_q;
                rdd_d    = to_mem_q ? rdd_q : dal_in;
                fifo_pop = to_mem_q;
                st_d     = ST_DONE;
            end
            ST_DONE: if (!bin.rply) begin
                addr_d = addr_q + `HBD_ADDR_STEP;
                cnt_d  = cnt_q - 3'h1;
                if (cnt_q == 3'h1) begin
                    sack_d = 1'b0;
                    busy_d = 1'b0;
                    st_d   = ST_IDLE;
                end else if (blk_q && ref_in) begin
                    st_d = ST_DATA;
                end else begin
                    st_d = ST_ADDR;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // master drive follows the state being entered
        if (st_d == ST_ADDR || st_d == ST_SYNC) begin
            dal_d     = addr_d[15:0];
            dal_oe_d  = 1'b1;
            xdal_d    = addr_d[21:16];
            xdal_oe_d = 1'b1;
            ctl_d.bs7  = (&addr_d[21:12]) || blk_d;
            ctl_d.wtbt = to_mem_d;
        end
        ctl_d.sync = (st_d == ST_SYNC || st_d == ST_DATA || st_d == ST_DONE);
        if (st_d == ST_DATA) begin
            if (to_mem_d) begin
                ctl_d.dout = fifo_valid;
                dal_d      = fifo_data;
                dal_oe_d   = 1'b1;
            end else begin
                ctl_d.din = 1'b1;
            end
        end
        // slave cycles only while we are not master
        slave_ok = (st_q == ST_IDLE || st_q == ST_REQ);
        if (bin.sync && !sync_in_q && slave_ok) begin
            sel_d = (dal_in[15:5] == P_CSR_BASE[15:5]);
            idx_d = dal_in[4:1];
        end else if (!bin.sync) begin
            sel_d = 1'b0;
        end
        if (sel_q && bin.din) begin
            ctl_d.rply = 1'b1;
            dal_d      = i_pio_rdata;
            dal_oe_d   = 1'b1;
            pio_d.rd   = !ctl_q.rply;
            pio_d.idx  = idx_q;
        end else if (sel_q && bin.dout) begin
            ctl_d.rply = 1'b1;
            pio_d.wr   = !ctl_q.rply;
            pio_d.idx  = idx_q;
            pio_d.data = dal_in;
        end
        // interrupt acknowledge
        req = pend_q && i_int_en;
        if (iak_in && bin.din && (req || hold_q)) begin
            ctl_d.rply = 1'b1;
            dal_d      = VEC_LUT[i_vec_sel];
            dal_oe_d   = 1'b1;
            hold_d     = 1'b1;
            pend_d     = 1'b0;
        end
        iako_d = iak_in && !req && !hold_q;
        dmgo_d = dmg_in && st_q == ST_IDLE && !i_dma_go;
        // a new event wins over the acknowledge clear in the same cycle
        evt = i_int_en && ((i_ready_flag && !rdy_q)
              || (i_attn && !attn_q && i_ready_flag)
              || (i_err && !err_q)
              || (i_int_en && !ie_q && i_ready_flag));
        if (!i_int_en) pend_d = 1'b0;
        if (evt) pend_d = 1'b1;
        irq_d  = pend_d && i_int_en;
        evnt_d = i_rtc_en && i_rtc_evt;
        if (init) begin
            st_d = ST_IDLE; dmr_d = 1'b0; sack_d = 1'b0; busy_d = 1'b0; ctl_d = '0;
            dal_oe_d = 1'b0; xdal_oe_d = 1'b0; sel_d = 1'b0; pio_d = '0; rdv_d = 1'b0;
            pend_d = 1'b0; irq_d = 1'b0; hold_d = 1'b0; dmgo_d = 1'b0; iako_d = 1'b0;
            evnt_d = 1'b0; fifo_pop = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= ST_IDLE; addr_q <= '0; to_mem_q <= 1'b0; blk_q <= 1'b0; cnt_q <= '0;
            dmr_q <= 1'b0; sack_q <= 1'b0; busy_q <= 1'b0; ctl_q <= '0; ctl_n_q <= '1;
            dal_n_q <= '1; dal_oe_q <= 1'b0; xdal_n_q <= '1; xdal_oe_q <= 1'b0;
            sel_q <= 1'b0; idx_q <= '0; pio_q <= '0; rdv_q <= 1'b0; rdd_q <= '0;
            pend_q <= 1'b0; irq_n_q <= 1'b1; hold_q <= 1'b0; evnt_n_q <= 1'b1;
            dmgo_q <= 1'b0; iako_q <= 1'b0; sync_in_q <= 1'b0;
            rdy_q <= 1'b0; attn_q <= 1'b0; err_q <= 1'b0; ie_q <= 1'b0;
        end else begin
            st_q <= st_d; addr_q <= addr_d; to_mem_q <= to_mem_d; blk_q <= blk_d; cnt_q <= cnt_d;
            dmr_q <= dmr_d; sack_q <= sack_d; busy_q <= busy_d; ctl_q <= ctl_d; ctl_n_q <= ~ctl_d;
            dal_n_q <= ~dal_d; dal_oe_q <= dal_oe_d; xdal_n_q <= ~xdal_d;
            xdal_oe_q <= xdal_oe_d; sel_q <= sel_d; idx_q <= idx_d; pio_q <= pio_d;
            rdv_q <= rdv_d; rdd_q <= rdd_d; pend_q <= pend_d; irq_n_q <= ~irq_d; hold_q <= hold_d;
            evnt_n_q <= ~evnt_d; dmgo_q <= dmgo_d; iako_q <= iako_d; sync_in_q <= bin.sync;
            rdy_q <= i_ready_flag; attn_q <= i_attn; err_q <= i_err; ie_q <= i_int_en;
        end
    end

    assign o_ctl_l    = ctl_n_q;
    assign o_ctl_oe   = ctl_q;
    assign o_dal_l    = dal_n_q;
    assign o_dal_oe   = dal_oe_q;
    assign o_xdal_l   = xdal_n_q;
    assign o_xdal_oe  = xdal_oe_q;
    assign o_dmr_l    = ~dmr_q;
    assign o_sack_l   = ~sack_q;
    assign o_dmgo_l   = ~dmgo_q;
    assign o_iako_l   = ~iako_q;
    assign o_irq5_l   = irq_n_q;
    assign o_evnt_l   = evnt_n_q;
    assign o_pio      = pio_q;
    assign o_dma_busy = busy_q;
    assign o_rd_valid = rdv_q;
    assign o_rd_data  = rdd_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_dmr_request: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (st_q == ST_IDLE && i_dma_go && !init) |=> !o_dmr_l) else $error("dma request not raised");
    a_sack_grant: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(sack_q) |-> $past(dmg_in) && $past(dmr_q)) else $error("acknowledge without grant");
    a_grant_block: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        dmr_q |=> o_dmgo_l) else $error("grant passed while requesting");
    a_bs7_bank: assert property (@(posedge i_mclk) disable iff (i_sys_rst || init)
        (st_q == ST_ADDR || st_q == ST_SYNC) |-> ctl_q.bs7 == ((&addr_q[21:12]) || blk_q))
        else $error("bank select wrong");
    a_sync_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(ctl_q.din) |-> ctl_q.sync && $past(ctl_q.sync)) else $error("data-in without sync");
    a_dout_rply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $fell(ctl_q.dout) |-> $past(bin.rply) || $past(init)) else $error("data-out dropped early");
    a_din_rply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $fell(ctl_q.din) |-> $past(bin.rply) || $past(init)) else $error("data-in dropped early");
    a_slave_reply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (sel_q && bin.dout && !bin.din && !ctl_q.rply && !init) |=> ctl_q.rply && o_pio.wr)
        else $error("slave write not answered");
    a_iak_fwd: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (iak_in && !(pend_q && i_int_en) && !hold_q && !init) |=> !o_iako_l) else $error("ack not forwarded");
    a_init_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        init |=> st_q == ST_IDLE && o_dmr_l && o_irq5_l && o_sack_l) else $error("init did not clear");
    a_ready_irq: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_ready_flag && !rdy_q && i_int_en && !init) |=> !o_irq5_l) else $error("ready gave no request");
    a_irq_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !i_int_en |=> o_irq5_l) else $error("request while disabled");
    a_burst_release: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (st_q == ST_DONE && !bin.rply && cnt_q == 3'h1) |=> o_sack_l && !ctl_q.sync && !o_dma_busy)
        else $error("bus kept after burst");
endmodule // hbd_port

// *** testbench/hbd_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host cpu, memory and grant arbiter
// ----------------------------------------
module hbd_host_model (
    input  wire logic              i_mclk,
    input  wire hbd_pkg::hbd_ctl_t i_ctl_l,
    input  wire logic [15:0]       i_dal_l,
    input  wire logic [5:0]        i_xdal_l,
    input  wire logic              i_dmr_l,
    input  wire logic              i_sack_l,
    output hbd_pkg::hbd_ctl_t      o_ctl_l,
    output logic [15:0]            o_dal_l,
    output logic                   o_dmgi_l,
    output logic                   o_iaki_l
);
    import hbd_pkg::*;
    logic [21:0] a_q;
    logic        bs7_q;
    logic        wt_q;
    logic        sync_q = 1'b1;
    int          cnt = 0;
    int          wait_n = 0;
    logic [15:0] mem [int];
    initial begin
        o_ctl_l  = '1;
        o_dal_l  = 16'hffff;
        o_dmgi_l = 1'b1;
        o_iaki_l = 1'b1;
    end
    function automatic logic [15:0] word(input logic [21:0] a, input logic b);
        return a[15:0] ^ {10'h0, a[21:16]} ^ {b, 15'h0};
    endfunction
    // released lines read as the pull-up level
    always @(posedge i_mclk) begin
        sync_q   <= i_ctl_l.sync;
        o_dmgi_l <= i_dmr_l | ~i_sack_l;
        if (!i_sack_l && !i_ctl_l.sync && sync_q) begin
            a_q   <= ~{i_xdal_l, i_dal_l};
            bs7_q <= ~i_ctl_l.bs7;
            wt_q  <= ~i_ctl_l.wtbt;
        end else if (!i_sack_l && !(i_ctl_l.din && i_ctl_l.dout) && o_ctl_l.rply) begin
            cnt <= cnt + 1;
            if (cnt >= wait_n) begin
                o_ctl_l.rply <= 1'b0;
                o_dal_l      <= i_ctl_l.din ? 16'hffff : ~word(a_q, bs7_q);
                if (i_ctl_l.din)
                    mem[a_q] = ~i_dal_l;
            end
        end else if (i_ctl_l.din && i_ctl_l.dout && !o_ctl_l.rply) begin
            o_ctl_l.rply <= 1'b1;
            o_dal_l      <= 16'hffff;
            a_q          <= a_q + 22'h2;
            cnt          <= 0;
        end
    end
    task automatic cycle(input logic [15:0] adr, input logic rd, input logic [15:0] wd, input logic iak,
                         output logic [15:0] q, output logic ok);
        int n;
        @(posedge i_mclk);
        o_dal_l      <= iak ? 16'hffff : ~adr;
        o_ctl_l.wtbt <= rd;
        @(posedge i_mclk);
        o_ctl_l.sync <= iak;
        @(posedge i_mclk);
        o_dal_l      <= rd ? 16'hffff : ~wd;
        o_ctl_l.wtbt <= 1'b1;
        o_ctl_l.din  <= ~rd;
        o_ctl_l.dout <= rd;
        o_iaki_l     <= ~iak;
        n  = 0;
        ok = 1'b0;
        while (n < 20 && !ok) begin
            @(posedge i_mclk);
            ok = (i_ctl_l.rply === 1'b0);
            n++;
        end
        q = ~i_dal_l;
        o_ctl_l.din  <= 1'b1;
        o_ctl_l.dout <= 1'b1;
        o_iaki_l     <= 1'b1;
        o_dal_l      <= 16'hffff;
        repeat (3) @(posedge i_mclk);
        o_ctl_l.sync <= 1'b1;
    endtask
endmodule // hbd_host_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb_top;
    import hbd_pkg::*;
    logic         i_mclk = 1'b0, i_sys_rst = 1'b1, i_init_l = 1'b1, i_ref_l = 1'b1, dmg_l = 1'b1, ok;
    logic         i_dma_go = 1'b0, i_wr_valid = 1'b0, i_ready_flag = 1'b0, i_attn = 1'b0, i_err = 1'b0;
    logic         i_int_en = 1'b0, i_vec_sel = 1'b0, i_rtc_en = 1'b0, i_rtc_evt = 1'b0;
    logic [15:0]  i_wr_data = 16'h0, i_pio_rdata = 16'h0, o_dal_l, o_rd_data, h_dal, dal_w, q;
    logic         o_dal_oe, o_xdal_oe, o_dmr_l, o_sack_l, o_dmgo_l, o_irq5_l, o_iako_l, o_evnt_l;
    logic         o_dma_busy, o_wr_ready, o_rd_valid, h_dmgi, h_iaki;
    logic [5:0]   o_xdal_l;
    hbd_ctl_t     o_ctl_l, o_ctl_oe, h_ctl, ctl_w;
    hbd_pio_t     o_pio;
    hbd_dma_cmd_t i_dma_cmd = '0;
    logic [31:0]  seed = 32'h1f3d;
    logic [15:0]  rd_q[$];
    logic [19:0]  pio_q[$];
    logic [3:0]   rdi_q[$];
    logic [15:0]  wq[9];
    int           miscompares = 0;
    int           n_compared = 0;
    assign ctl_w = hbd_ctl_t'((o_ctl_l | ~o_ctl_oe) & h_ctl);
    assign dal_w = (o_dal_oe ? o_dal_l : 16'hffff) & h_dal;
    hbd_port u_dut (.i_mclk, .i_sys_rst, .i_init_l, .i_ctl_l(ctl_w), .o_ctl_l, .o_ctl_oe, .i_dal_l(dal_w),
        .o_dal_l, .o_dal_oe, .o_xdal_l, .o_xdal_oe, .i_ref_l, .o_dmr_l, .o_sack_l, .i_dmgi_l(h_dmgi & dmg_l),
        .o_dmgo_l, .o_irq5_l, .i_iaki_l(h_iaki), .o_iako_l, .o_evnt_l, .o_pio, .i_pio_rdata, .i_dma_go,
        .i_dma_cmd, .o_dma_busy, .i_wr_valid, .o_wr_ready, .i_wr_data, .o_rd_valid, .o_rd_data,
        .i_ready_flag, .i_attn, .i_err, .i_int_en, .i_vec_sel, .i_rtc_en, .i_rtc_evt);
    hbd_host_model u_host (.i_mclk, .i_ctl_l(ctl_w), .i_dal_l(dal_w), .i_xdal_l(o_xdal_oe ? o_xdal_l : 6'h3f),
        .i_dmr_l(o_dmr_l), .i_sack_l(o_sack_l), .o_ctl_l(h_ctl), .o_dal_l(h_dal), .o_dmgi_l(h_dmgi),
        .o_iaki_l(h_iaki));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // expected words are noted by the driver, taken off here as they appear
    always @(posedge i_mclk) begin
        if (o_rd_valid === 1'b1)
            check("rd_data", o_rd_data, rd_q.pop_front());
        if (o_pio.wr === 1'b1)
            check("pio_wr", {o_pio.idx, o_pio.data}, pio_q.pop_front());
        if (o_pio.rd === 1'b1)
            check("pio_rd_idx", o_pio.idx, rdi_q.pop_front());
    end
    task automatic dma(input logic [21:0] a, input logic wr, input logic b4, input logic blk);
        int n;
        for (n = 0; n < (b4 ? 4 : 2); n++)
            if (!wr)
                rd_q.push_back(u_host.word(a + 22'(2 * n), blk | (&a[21:12])));
        @(posedge i_mclk);
        i_dma_cmd <= '{addr: a, to_mem: wr, burst4: b4, block: blk};
        i_dma_go  <= 1'b1;
        @(posedge i_mclk);
        i_dma_go  <= 1'b0;
        n = 0;
        tick(1);
        while (n < 400 && o_dma_busy !== 1'b0) begin
            tick(1);
            n++;
        end
        check("burst_left", rd_q.size(), 0);
        check("released", {o_sack_l, ctl_w.sync, o_dal_oe}, 3'h6);
        check("dma_done", o_dma_busy, 1'b0);
        check("wtbt", u_host.wt_q, wr);
    endtask
    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        #1000000;
        miscompares++;
        complete_run();
    end
    initial begin
        int k;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        tick(0);
        check("rst_out", {o_dmr_l, o_sack_l, o_irq5_l, o_wr_ready, o_dma_busy}, 5'h1e);
        for (k = 0; k < 4; k++) begin
            wq[0] = 16'(rnd());
            pio_q.push_back({4'(k * 5), wq[0]});
            u_host.cycle(16'hff20 + 16'(k * 10), 1'b0, wq[0], 1'b0, q, ok);
            check("pio_ack", ok, 1'b1);
            @(posedge i_mclk);
            i_pio_rdata <= 16'(rnd());
            rdi_q.push_back(4'(k * 5));
            u_host.cycle(16'hff20 + 16'(k * 10), 1'b1, 16'h0, 1'b0, q, ok);
            check("pio_rd", q, i_pio_rdata);
        end
        u_host.cycle(16'hff00, 1'b1, 16'h0, 1'b0, q, ok);
        check("unmapped", ok, 1'b0);
        for (k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            i_ref_l <= ~k[1];
            u_host.wait_n = k;
            dma(k[0] ? 22'h3ff000 : 22'(rnd()) & 22'h3ffff0, 1'b0, k[0], k[1]);
        end
        k = 0;
        while (k < 9) begin
            @(posedge i_mclk);
            wq[k] = 16'(rnd());
            i_wr_valid <= 1'b1;
            i_wr_data  <= wq[k];
            @(negedge i_mclk);
            if (o_wr_ready !== 1'b1)
                break;
            k++;
        end
        @(posedge i_mclk);
        i_wr_valid <= 1'b0;
        check("fifo_fill", k, 8);
        for (k = 0; k < 2; k++)
            dma(22'h001000 + 22'(k * 8), 1'b1, 1'b1, 1'b0);
        for (k = 0; k < 8; k++)
            check("mem_wr", u_host.mem[32'h1000 + k * 2], wq[k]);
        check("no_extra", u_host.mem.exists(32'h1010), 0);
        check("fifo_empty", o_wr_ready, 1'b1);
        @(posedge i_mclk);
        dmg_l     <= 1'b0;
        i_rtc_en  <= 1'b1;
        i_rtc_evt <= 1'b1;
        i_int_en  <= 1'b1;
        tick(1);
        check("chain_evnt", {o_dmgo_l, o_evnt_l}, 2'h0);
        for (k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            dmg_l     <= 1'b1;
            i_rtc_en  <= 1'b0;
            i_vec_sel <= k[0];
            case (k)
                0: i_ready_flag <= 1'b1;
                1: i_err <= 1'b1;
                2: i_attn <= 1'b1;
                default: i_int_en <= 1'b1;
            endcase
            tick(2);
            check("irq", o_irq5_l, 1'b0);
            u_host.cycle(16'h0, 1'b1, 16'h0, 1'b1, q, ok);
            check("vector", q, k[0] ? 16'h00ac : 16'h0088);
            tick(1);
            check("irq_off", {o_irq5_l, o_evnt_l}, 2'h3);
            @(posedge i_mclk);
            i_int_en <= (k != 2);
        end
        // nothing pending: the acknowledge must leave on the chain output while it is held
        fork
            u_host.cycle(16'h0, 1'b1, 16'h0, 1'b1, q, ok);
            begin
                tick(5);
                check("iak_fwd", o_iako_l, 1'b0);
            end
        join
        check("iak_pass", ok, 1'b0);
        @(posedge i_mclk);
        i_err <= 1'b0;
        @(posedge i_mclk);
        i_err    <= 1'b1;
        i_init_l <= 1'b0;
        @(posedge i_mclk);
        i_init_l <= 1'b1;
        tick(2);
        check("init_clr", o_irq5_l, 1'b1);
        check("pio_left", pio_q.size() + rdi_q.size(), 0);
        complete_run();
    end
endmodule // tb_top
